// >>> src/line_alarm_pkg.sv
// constants and carrier types for the channel alarm and transmit monitor
// How it works
// - digital loss declared after 160 silent bits
// - digital loss clears at 33% pulse density
// - alarm bit 5 shows digital loss
// - channel loss is analog or digital loss, the e3 detector in e3 mode
// - alarm bit 4 shows hysteretic analog loss
// - alarm bit 3 shows fifo near limits
// - fifo alarm only with attenuator enabled
// - alarm bit 2 shows clock lock loss
// - alarm bit 1 shows channel loss
// - drive alarm after 128 pulseless bits
// - control bit 5 selects watch source
// - rising control bit 4 injects one error
// - injection only with generator and receiver enabled
// - alarm bit 6 shows pattern lock loss
// - each change of alarm bits 0 to 3 sets read-cleared change bit
package line_alarm_pkg;
	localparam logic [3:0] alarm_state_addr = 4'h3;
	localparam logic [3:0] change_status_addr = 4'h2;
	localparam logic [3:0] tx_control_addr = 4'h4;
	localparam logic [7:0] tx_control_reset = 8'h00;
	localparam int dlos_declare_bits = 160;
	localparam int dlos_window_bits = 32;
	localparam int dlos_clear_pulses = 11; // 11/32 is at least 33%
	localparam int dmo_declare_bits = 128;
	localparam int bit_watch_pos = 5;
	localparam int bit_insert_pos = 4;
	localparam int bit_prbs_loss = 6;
	localparam int bit_dlos = 5;
	localparam int bit_alos = 4;
	localparam int bit_fifo = 3;
	localparam int bit_lol = 2;
	localparam int bit_los = 1;
	localparam int bit_dmo = 0;
	// register bus access
	typedef struct packed {
		logic [3:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cpu_req_type;
	// raw analog and receive-side indications
	typedef struct packed {
		logic amp_below_declare;
		logic amp_above_clear;
		logic fifo_near_limit;
		logic freq_off_by_limit;
		logic e3_los;
		logic prbs_sync_loss;
	} rx_ind_type;
endpackage

// >>> src/line_alarm_status.sv
// per-channel alarm detectors, alarm state and transmit control registers
`timescale 1ns/10ps
module line_alarm_status (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register access
	input wire line_alarm_pkg::cpu_req_type cpu_req,
	output logic [7:0] cpu_rdata,
	// line bit timing and data, already on mclk
	input wire logic bit_tick,
	input wire logic rx_pulse,
	input wire logic tx_line_pos_pad,
	input wire logic tx_line_neg_pad,
	// external watch pins, asynchronous
	input wire logic watch_pos_input,
	input wire logic watch_neg_input,
	// receive indications and mode
	input wire line_alarm_pkg::rx_ind_type rx_ind,
	input wire logic e3_mode,
	input wire logic jitter_atten_en,
	input wire logic prbs_gen_en,
	input wire logic prbs_rx_en,
	// outputs
	output logic prbs_error_inject,
	output logic signal_loss,
	output logic drive_watch_alarm,
	output logic [7:0] tx_control
);
	// register state, detector counters and helper nets
	logic [7:0] tx_control_q;
	logic ins_prev_q;
	logic [1:0] wp_q, wn_q; // watch pin synchronisers
	logic [7:0] dlos_cnt_q;
	logic dlos_q;
	logic [5:0] win_cnt_q, win_pulses_q;
	logic [5:0] win_total; // window pulses including the closing bit
	logic alos_q;
	logic [7:0] dmo_cnt_q;
	logic dmo_q;
	logic [7:0] alarm_now; // live alarm word
	logic [3:0] alarm_prev_q; // last state of tracked alarms
	logic [3:0] change_q, change_ev;
	logic watch_pulse, fifo_alarm, rd_change;
	logic inject_q;

	// transmit control register, software write only
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_control_q <= line_alarm_pkg::tx_control_reset;
		end else if (cpu_req.wr && cpu_req.addr ==
				line_alarm_pkg::tx_control_addr) begin
			// reserved bits 7, 6 and 3 never store a one
			tx_control_q <= {2'b00, cpu_req.wdata[5:4], 1'b0,
				cpu_req.wdata[2:0]};
		end
	end
	assign tx_control = tx_control_q;

	// error insertion: edge of bit 4, gated by both prbs enables
	// a held 1 gives nothing more; software must rewrite 0 first
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ins_prev_q <= 1'b0;
			inject_q <= 1'b0;
		end else begin
			ins_prev_q <= tx_control_q[line_alarm_pkg::bit_insert_pos];
			inject_q <= tx_control_q[line_alarm_pkg::bit_insert_pos] &&
				!ins_prev_q && prbs_gen_en && prbs_rx_en;
		end
	end
	// one clock wide; the generator flips a single bit on it
	assign prbs_error_inject = inject_q;

	// two-flop synchroniser for the external watch pins
	// only the second stage is read; the first may still be settling
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wp_q <= 2'b00;
			wn_q <= 2'b00;
		end else begin
			wp_q <= {wp_q[0], watch_pos_input};
			wn_q <= {wn_q[0], watch_neg_input};
		end
	end
	// internal pads or external pins as watch source
	assign watch_pulse = tx_control_q[line_alarm_pkg::bit_watch_pos] ?
		(tx_line_pos_pad | tx_line_neg_pad) : (wp_q[1] | wn_q[1]);

	// drive monitor: count pulseless bit periods, clear on a pulse
	// the count stops at its end value, so the alarm holds without wrap
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dmo_cnt_q <= 8'h00;
			dmo_q <= 1'b0;
		end else if (bit_tick) begin
			if (watch_pulse) begin
				dmo_cnt_q <= 8'h00;
				dmo_q <= 1'b0;
			end else if (dmo_cnt_q ==
					8'(line_alarm_pkg::dmo_declare_bits - 1)) begin
				dmo_q <= 1'b1;
			end else begin
				dmo_cnt_q <= dmo_cnt_q + 8'h01;
			end
		end
	end

	// digital loss: silent run count declares
	// saturating count: a long outage never wraps back to a false quiet
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dlos_cnt_q <= 8'h00;
		end else if (bit_tick) begin
			if (rx_pulse) begin
				dlos_cnt_q <= 8'h00;
			end else if (dlos_cnt_q !=
					8'(line_alarm_pkg::dlos_declare_bits)) begin
				dlos_cnt_q <= dlos_cnt_q + 8'h01;
			end
		end
	end

	// density window: pulses per fixed window of bits
	// fixed windows are cheap; a pulse burst split over two windows
	// may clear one window later than a sliding measure would
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			win_cnt_q <= 6'h00;
			win_pulses_q <= 6'h00;
		end else if (bit_tick) begin
			if (win_cnt_q == 6'(line_alarm_pkg::dlos_window_bits - 1)) begin
				win_cnt_q <= 6'h00;
				win_pulses_q <= 6'h00;
			end else begin
				win_cnt_q <= win_cnt_q + 6'h01;
				win_pulses_q <= win_pulses_q + {5'h00, rx_pulse};
			end
		end
	end

	// the closing bit of a window counts toward its density too
	assign win_total = win_pulses_q + {5'h00, rx_pulse};

	// digital loss state: declare on silence, clear on density; e3 off
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dlos_q <= 1'b0;
		end else if (e3_mode) begin
			dlos_q <= 1'b0;
		end else if (bit_tick && rx_pulse == 1'b0 && dlos_cnt_q ==
				8'(line_alarm_pkg::dlos_declare_bits - 1)) begin
			dlos_q <= 1'b1;
		end else if (bit_tick && dlos_q && win_cnt_q ==
				6'(line_alarm_pkg::dlos_window_bits - 1) &&
				win_total >= 6'(line_alarm_pkg::dlos_clear_pulses)) begin
			dlos_q <= 1'b0;
		end
	end

	// analog loss with hysteresis between two thresholds
	// both flags at once: declare wins, since loss is the safe side
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			alos_q <= 1'b0;
		end else if (e3_mode) begin
			alos_q <= 1'b0;
		end else if (rx_ind.amp_below_declare) begin
			alos_q <= 1'b1;
		end else if (rx_ind.amp_above_clear) begin
			alos_q <= 1'b0;
		end
	end

	// live alarm word; reserved bit 7 reads zero
	// reads see current detector state; nothing here is latched
	assign fifo_alarm = rx_ind.fifo_near_limit & jitter_atten_en;
	always_comb begin
		alarm_now = 8'h00;
		alarm_now[line_alarm_pkg::bit_prbs_loss] = rx_ind.prbs_sync_loss;
		alarm_now[line_alarm_pkg::bit_dlos] = dlos_q;
		alarm_now[line_alarm_pkg::bit_alos] = alos_q;
		alarm_now[line_alarm_pkg::bit_fifo] = fifo_alarm;
		alarm_now[line_alarm_pkg::bit_lol] = rx_ind.freq_off_by_limit;
		// channel loss takes the e3 detector in e3, the wired or otherwise
		alarm_now[line_alarm_pkg::bit_los] = e3_mode ? rx_ind.e3_los :
			(dlos_q | alos_q);
		alarm_now[line_alarm_pkg::bit_dmo] = dmo_q;
	end
	assign signal_loss = alarm_now[line_alarm_pkg::bit_los];
	assign drive_watch_alarm = dmo_q;

	// change detection; a set in the read cycle wins over the clear
	// only the four low alarms carry change bits
	assign rd_change = cpu_req.rd &&
		cpu_req.addr == line_alarm_pkg::change_status_addr;
	assign change_ev = alarm_now[3:0] ^ alarm_prev_q[3:0];
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			alarm_prev_q <= 4'h0;
			change_q <= 4'h0;
		end else begin
			alarm_prev_q <= alarm_now[3:0];
			change_q <= (rd_change ? 4'h0 : change_q) | change_ev;
		end
	end

	// read data registered; writes to alarm state ignored
	// the alarm word has no write path, so a write cannot disturb it
	// unmapped addresses read back as zero
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cpu_rdata <= 8'h00;
		end else if (cpu_req.rd) begin
			unique case (cpu_req.addr)
				line_alarm_pkg::alarm_state_addr: cpu_rdata <= alarm_now;
				line_alarm_pkg::change_status_addr:
					cpu_rdata <= {4'h0, change_q};
				line_alarm_pkg::tx_control_addr: cpu_rdata <= tx_control_q;
				default: cpu_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// >>> dv/line_partner.sv
// line side model: bit ticks, receive pulses and bipolar pads
`timescale 1ns/10ps
module line_partner (
	// clock and activity enables
	input wire logic mclk, rx_on, tx_on,
	// line side outputs
	output logic bit_tick, rx_pulse, tx_line_pos_pad, tx_line_neg_pad
);
	logic [2:0] c = 3'h0; // four clocks per bit, bit 2 picks polarity
	initial {bit_tick, rx_pulse, tx_line_pos_pad, tx_line_neg_pad} = 4'h0;
	// pads alternate so a live line shows true bipolar pulses
	always @(posedge mclk) begin
		c <= c + 3'h1;
		bit_tick <= c[1:0] == 2'h3;
		rx_pulse <= rx_on;
		tx_line_pos_pad <= tx_on && !c[2];
		tx_line_neg_pad <= tx_on && c[2];
	end
endmodule

// >>> dv/line_alarm_monitor.sv
// assertions on the alarm block ports
`timescale 1ns/10ps
module line_alarm_monitor (
	// clock, reset and watched ports
	input wire logic mclk, rst_b, bit_tick, e3_mode,
	input wire line_alarm_pkg::cpu_req_type cpu_req,
	input wire line_alarm_pkg::rx_ind_type rx_ind,
	input wire logic prbs_gen_en, prbs_rx_en, prbs_error_inject,
	input wire logic signal_loss, drive_watch_alarm,
	input wire logic [7:0] cpu_rdata, tx_control
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_inject_single: assert property (
		prbs_error_inject |=> !prbs_error_inject) else $error("long inject");
	chk_inject_cause: assert property (
		$rose(tx_control[4]) && prbs_gen_en && prbs_rx_en
		|=> prbs_error_inject) else $error("no inject");
	chk_inject_gate: assert property (
		prbs_error_inject |-> $past(prbs_gen_en) && $past(prbs_rx_en))
		else $error("inject off");
	chk_ctrl_write: assert property (
		cpu_req.wr && cpu_req.addr == 4'h4
		|=> tx_control == ($past(cpu_req.wdata) & 8'h37)) else $error("ctrl");
	chk_e3_loss: assert property (
		e3_mode |-> signal_loss == rx_ind.e3_los) else $error("e3 loss");
	chk_analog_loss: assert property (
		!e3_mode && rx_ind.amp_below_declare |-> ##[0:2] signal_loss)
		else $error("analog loss");
	chk_drive_tick: assert property (
		$rose(drive_watch_alarm) |-> $past(bit_tick)) else $error("drive");
	chk_alarm_read: assert property (
		cpu_req.rd && cpu_req.addr == 4'h3 |=> !cpu_rdata[7]
		&& cpu_rdata[0] == $past(drive_watch_alarm)) else $error("alarm");
	cover property (prbs_error_inject);
	cover property (drive_watch_alarm);
	cover property (signal_loss && !e3_mode);
endmodule
bind line_alarm_status line_alarm_monitor mon (.mclk, .rst_b, .bit_tick,
	.e3_mode, .cpu_req, .rx_ind, .prbs_gen_en, .prbs_rx_en, .prbs_error_inject,
	.signal_loss, .drive_watch_alarm, .cpu_rdata, .tx_control);

// >>> dv/tb_line_alarm_status.sv
// self-checking bench for the channel alarm block
`timescale 1ns/10ps
module tb_line_alarm_status;
	logic mclk = 0, rst_b = 0, rx_on = 1, tx_on = 1, e3_mode = 0;
	logic jitter_atten_en = 0, prbs_gen_en = 1, prbs_rx_en = 1, pins_on = 1;
	line_alarm_pkg::cpu_req_type cpu_req = '0;
	line_alarm_pkg::rx_ind_type rx_ind = '0;
	logic [7:0] cpu_rdata, tx_control;
	logic bit_tick, rx_pulse, tx_line_pos_pad, tx_line_neg_pad;
	logic prbs_error_inject, signal_loss, drive_watch_alarm;
	int n_fail = 0, check_count = 0, n_inj = 0;
	line_partner lp (.mclk, .rx_on, .tx_on, .bit_tick, .rx_pulse,
		.tx_line_pos_pad, .tx_line_neg_pad);
	line_alarm_status dut (.mclk, .rst_b, .cpu_req, .cpu_rdata, .bit_tick,
		.rx_pulse, .tx_line_pos_pad, .tx_line_neg_pad, .rx_ind, .e3_mode,
		.watch_pos_input(tx_line_pos_pad & pins_on),
		.watch_neg_input(tx_line_neg_pad & pins_on),
		.jitter_atten_en, .prbs_gen_en, .prbs_rx_en, .prbs_error_inject,
		.signal_loss, .drive_watch_alarm, .tx_control);
	initial forever #10 mclk = ~mclk;
	always @(negedge mclk) if (prbs_error_inject === 1'b1) n_inj++;
	task automatic cmp(input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h %h", $time, e, g);
		end
	endtask
	// one access; a read compares the masked data
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d,
		input logic [7:0] m = 8'h00, e = 8'h00);
		@(negedge mclk) cpu_req = '{a, w, !w, d};
		@(negedge mclk) cpu_req = '0;
		@(negedge mclk) if (!w) cmp(e, cpu_rdata & m);
	endtask
	task automatic t_regs();
		acc(4'h4, 1, 8'hff);
		cmp(8'h37, tx_control);
		acc(4'h4, 0, 0, 8'hff, 8'h37);
		acc(4'h3, 1, 8'hff);
		acc(4'h3, 0, 0, 8'hff, 8'h00);
	endtask
	task automatic t_inj();
		int n0;
		acc(4'h4, 1, 8'h00);
		n0 = n_inj;
		acc(4'h4, 1, 8'h10);
		acc(4'h4, 1, 8'h10);
		cmp(8'h01, 8'(n_inj - n0));
		prbs_gen_en = 0;
		acc(4'h4, 1, 8'h00);
		acc(4'h4, 1, 8'h10);
		cmp(8'h01, 8'(n_inj - n0));
	endtask
	task automatic t_dmo();
		acc(4'h4, 1, 8'h20);
		tx_on = 0;
		pins_on = 0;
		repeat (504) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h01, 8'h00);
		repeat (16) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h01, 8'h01);
		cmp(8'h01, {7'h00, drive_watch_alarm});
		tx_on = 1;
		repeat (8) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h01, 8'h00);
		acc(4'h4, 1, 8'h00);
		repeat (520) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h01, 8'h01);
		pins_on = 1;
		repeat (8) @(negedge mclk);
		cmp(8'h00, {7'h00, drive_watch_alarm});
	endtask
	task automatic t_los();
		rx_on = 0;
		repeat (632) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h22, 8'h00);
		repeat (16) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h22, 8'h22);
		cmp(8'h01, {7'h00, signal_loss});
		rx_on = 1;
		repeat (280) @(negedge mclk);
		acc(4'h3, 0, 0, 8'h22, 8'h00);
		acc(4'h2, 0, 0, 8'h02, 8'h02);
	endtask
	task automatic t_ind();
		rx_ind = 6'h0d;
		acc(4'h3, 0, 0, 8'h4c, 8'h44);
		jitter_atten_en = 1;
		acc(4'h3, 0, 0, 8'h08, 8'h08);
		rx_ind = 6'h20;
		acc(4'h3, 0, 0, 8'h5e, 8'h12);
		rx_ind = 6'h00;
		acc(4'h3, 0, 0, 8'h12, 8'h12);
		rx_ind = 6'h10;
		acc(4'h3, 0, 0, 8'h12, 8'h00);
		e3_mode = 1;
		acc(4'h3, 0, 0, 8'h32, 8'h00);
		rx_ind = 6'h02;
		acc(4'h3, 0, 0, 8'h32, 8'h02);
		acc(4'h2, 0, 0, 8'h0f, 8'h0e);
		acc(4'h2, 0, 0, 8'h0f, 8'h00);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		rst_b = 1;
		t_regs();
		t_inj();
		t_dmo();
		t_los();
		t_ind();
		test_done();
	end
endmodule
